/* hdl/vmecc_checker.sv */
// vm entry control capability registers and entry validity checker
`timescale 1ns/10ps
`default_nettype none
module vmecc_checker #(
	parameter logic TRUE_CAP = 1'b1,
	parameter logic [31:0] REVISION_ID = 32'h0000_0001, // arbitrary value
	parameter logic [12:0] REGION_SIZE = 13'h1000,
	parameter logic [3:0] MEM_TYPE = vmecc_pkg::VMECC_MT_WB,
	parameter logic [63:0] PIN_CAP_RAW = 64'h0000_003F_0000_0000,
	parameter logic [63:0] PRI_CAP_RAW = 64'hFFFF_FFFF_0000_0000,
	parameter logic [63:0] SEC_CAP = 64'h0000_00FF_0000_0000,
	parameter logic [63:0] TPIN_CAP = 64'h0000_003F_0000_0000,
	parameter logic [63:0] TPRI_CAP = 64'hFFFF_FFFF_0000_0000
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	// capability register read/write port
	input wire logic cap_rd,
	input wire logic cap_wr,
	input wire logic [11:0] cap_index,
	input wire logic virt_present,
	output logic [63:0] cap_rdata,
	output logic cap_rvalid,
	output logic cap_fault,
	// entry check request
	input wire logic entry_req,
	input wire logic [31:0] pin_controls,
	input wire logic [31:0] primary_controls,
	output logic entry_done,
	output logic entry_fail,
	output logic pin_fail,
	output logic primary_fail,
	// memory type for control structure accesses
	input wire logic range_enable,
	input wire logic cache_disable_setting,
	input wire logic sibling_cache_disable,
	output logic [3:0] struct_mem_type
);
	import vmecc_pkg::*;

	// ------------------------------------------------------------
	// capability register contents
	// ------------------------------------------------------------
	logic [63:0] basic_capability_info;
	logic [63:0] pin_control_capability;
	logic [63:0] primary_control_capability;

	// reported memory type is a constant field, untouched by range
	// enable or cache disable
	always_comb begin
		basic_capability_info = VMECC_ZERO64;
		basic_capability_info[31:0] = REVISION_ID;
		basic_capability_info[44:32] = REGION_SIZE;
		basic_capability_info[VMECC_MT_HI:VMECC_MT_LO] = MEM_TYPE;
		basic_capability_info[VMECC_TRUE_BIT] = TRUE_CAP;
	end

	// reserved-one class forced to required-one in the low halves
	always_comb begin
		pin_control_capability = PIN_CAP_RAW;
		pin_control_capability[31:0] = PIN_CAP_RAW[31:0] |
			VMECC_PIN_ONE_MASK;
		primary_control_capability = PRI_CAP_RAW;
		primary_control_capability[31:0] = PRI_CAP_RAW[31:0] |
			VMECC_PRI_ONE_MASK;
	end

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// one bit per control that breaks its allowed 0 / allowed 1 pair
	function automatic logic [31:0] bad_bits(input logic [31:0] ctl,
		input logic [63:0] cap);
		bad_bits = (~ctl & cap[31:0]) | (ctl & ~cap[63:32]);
	endfunction

	// true registers take over only when the true bit is set; the
	// original ones then stay readable but no longer steer the check
	function automatic logic [63:0] eff_cap(input logic use_true,
		input logic [63:0] orig, input logic [63:0] tcap);
		eff_cap = use_true ? tcap : orig;
	endfunction

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	logic [63:0] cap_rdata_q, cap_rdata_d;
	logic cap_rvalid_q, cap_rvalid_d;
	logic cap_fault_q, cap_fault_d;

	// writes always fault; the true registers exist only with the
	// true bit set, and nothing exists without virtualization support
	always_comb begin
		cap_rdata_d = VMECC_ZERO64;
		cap_rvalid_d = 1'b0;
		cap_fault_d = 1'b0;
		if (cap_wr) begin
			cap_fault_d = 1'b1;
		end else if (cap_rd) begin
			cap_rvalid_d = 1'b1;
			if (!virt_present) begin
				cap_fault_d = 1'b1;
			end else begin
				case (cap_index)
					VMECC_IDX_BASIC: cap_rdata_d = basic_capability_info;
					VMECC_IDX_PIN: cap_rdata_d = pin_control_capability;
					VMECC_IDX_PRI: cap_rdata_d = primary_control_capability;
					VMECC_IDX_SEC: cap_rdata_d = SEC_CAP;
					VMECC_IDX_TPIN: begin
						if (TRUE_CAP) begin
							cap_rdata_d = TPIN_CAP;
						end else begin
							cap_fault_d = 1'b1;
						end
					end
					VMECC_IDX_TPRI: begin
						if (TRUE_CAP) begin
							cap_rdata_d = TPRI_CAP;
						end else begin
							cap_fault_d = 1'b1;
						end
					end
					default: cap_fault_d = 1'b1;
				endcase
			end
			if (cap_fault_d) begin
				cap_rvalid_d = 1'b0;
			end
		end
	end

	// read port registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cap_rdata_q <= VMECC_ZERO64;
			cap_rvalid_q <= 1'b0;
			cap_fault_q <= 1'b0;
		end else begin
			cap_rdata_q <= cap_rdata_d;
			cap_rvalid_q <= cap_rvalid_d;
			cap_fault_q <= cap_fault_d;
		end
	end

	// ------------------------------------------------------------
	// entry checker: two stages, evaluate then report
	// ------------------------------------------------------------
	typedef enum logic [1:0] {VMECC_IDLE, VMECC_EVAL} vmecc_state_t;
	vmecc_state_t state_q, state_d;
	logic [31:0] pin_bad_q, pin_bad_d;
	logic [31:0] pri_bad_q, pri_bad_d;
	logic entry_done_q, entry_done_d;
	logic entry_fail_q, entry_fail_d;
	logic pin_fail_q, pin_fail_d;
	logic pri_fail_q, pri_fail_d;
	logic [63:0] pin_eff, pri_eff;

	// with the true bit clear the original low half already carries
	// ones for the reserved-one class, so a zero there fails entry
	assign pin_eff = eff_cap(TRUE_CAP, pin_control_capability,
		TPIN_CAP);
	assign pri_eff = eff_cap(TRUE_CAP, primary_control_capability,
		TPRI_CAP);

	// controls are latched in the request cycle; a request in the
	// report cycle is ignored, so checks start at most every other cycle
	always_comb begin
		state_d = state_q;
		pin_bad_d = pin_bad_q;
		pri_bad_d = pri_bad_q;
		entry_done_d = 1'b0;
		entry_fail_d = entry_fail_q;
		pin_fail_d = pin_fail_q;
		pri_fail_d = pri_fail_q;
		case (state_q)
			VMECC_IDLE: begin
				if (entry_req) begin
					pin_bad_d = bad_bits(pin_controls, pin_eff);
					pri_bad_d = bad_bits(primary_controls, pri_eff);
					state_d = VMECC_EVAL;
				end
			end
			VMECC_EVAL: begin
				pin_fail_d = |pin_bad_q;
				pri_fail_d = |pri_bad_q;
				entry_fail_d = (|pin_bad_q) | (|pri_bad_q);
				entry_done_d = 1'b1;
				state_d = VMECC_IDLE;
			end
			default: state_d = VMECC_IDLE;
		endcase
	end

	// checker registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= VMECC_IDLE;
			pin_bad_q <= 32'h0;
			pri_bad_q <= 32'h0;
			entry_done_q <= 1'b0;
			entry_fail_q <= 1'b0;
			pin_fail_q <= 1'b0;
			pri_fail_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pin_bad_q <= pin_bad_d;
			pri_bad_q <= pri_bad_d;
			entry_done_q <= entry_done_d;
			entry_fail_q <= entry_fail_d;
			pin_fail_q <= pin_fail_d;
			pri_fail_q <= pri_fail_d;
		end
	end

	// ------------------------------------------------------------
	// memory type for structure accesses
	// ------------------------------------------------------------
	logic [3:0] mt_q, mt_d;
	logic [2:0] rng_sync_q, cd_sync_q, sib_sync_q;
	logic [2:0] rng_sync_d, cd_sync_d, sib_sync_d;
	logic rng_q, cd_q, sib_q, rng_d, cd_d, sib_d;

	// levels from other logic pass three flops; a change counts once
	// the last two agree, which filters a single-cycle glitch
	always_comb begin
		rng_sync_d = {rng_sync_q[1:0], range_enable};
		cd_sync_d = {cd_sync_q[1:0], cache_disable_setting};
		sib_sync_d = {sib_sync_q[1:0], sibling_cache_disable};
		rng_d = (rng_sync_q[2] == rng_sync_q[1]) ? rng_sync_q[1] : rng_q;
		cd_d = (cd_sync_q[2] == cd_sync_q[1]) ? cd_sync_q[1] : cd_q;
		sib_d = (sib_sync_q[2] == sib_sync_q[1]) ? sib_sync_q[1] : sib_q;
		mt_d = MEM_TYPE;
		if (!rng_q) begin
			mt_d = VMECC_MT_UNCACHED;
		end
		if (cd_q || sib_q) begin
			mt_d = VMECC_MT_UNCACHED;
		end
	end

	// memory type registers; ranges assumed enabled out of reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rng_sync_q <= 3'h7;
			cd_sync_q <= 3'h0;
			sib_sync_q <= 3'h0;
			rng_q <= 1'b1;
			cd_q <= 1'b0;
			sib_q <= 1'b0;
			mt_q <= VMECC_MT_UNCACHED;
		end else begin
			rng_sync_q <= rng_sync_d;
			cd_sync_q <= cd_sync_d;
			sib_sync_q <= sib_sync_d;
			rng_q <= rng_d;
			cd_q <= cd_d;
			sib_q <= sib_d;
			mt_q <= mt_d;
		end
	end

	assign cap_rdata = cap_rdata_q;
	assign cap_rvalid = cap_rvalid_q;
	assign cap_fault = cap_fault_q;
	assign entry_done = entry_done_q;
	assign entry_fail = entry_fail_q;
	assign pin_fail = pin_fail_q;
	assign primary_fail = pri_fail_q;
	assign struct_mem_type = mt_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_write_faults: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		cap_wr |=> cap_fault && !cap_rvalid)
		else $error("write to capability register did not fault");
	a_pin_low_ones: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cap_rd && !cap_wr && virt_present && cap_index == VMECC_IDX_PIN)
		|=> (cap_rdata[31:0] & VMECC_PIN_ONE_MASK) == VMECC_PIN_ONE_MASK)
		else $error("pin capability reserved-one bits not set");
	a_pri_low_ones: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cap_rd && !cap_wr && virt_present && cap_index == VMECC_IDX_PRI)
		|=> (cap_rdata[31:0] & VMECC_PRI_ONE_MASK) == VMECC_PRI_ONE_MASK)
		else $error("primary capability reserved-one bits not set");
	a_true_absent: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(!TRUE_CAP && cap_rd && !cap_wr && cap_index == VMECC_IDX_TPIN)
		|=> cap_fault)
		else $error("true register readable with true bit clear");
	a_pin_fail: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == VMECC_IDLE && entry_req &&
		|bad_bits(pin_controls, pin_eff)) |-> ##2 (entry_fail && pin_fail))
		else $error("pin violation did not fail entry");
	a_pri_fail: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == VMECC_IDLE && entry_req &&
		|bad_bits(primary_controls, pri_eff)) |-> ##2 primary_fail)
		else $error("primary violation did not fail entry");
	a_entry_clean: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state_q == VMECC_IDLE && entry_req &&
		bad_bits(pin_controls, pin_eff) == 32'h0 &&
		bad_bits(primary_controls, pri_eff) == 32'h0)
		|-> ##2 (entry_done && !entry_fail))
		else $error("clean controls failed entry");
	a_range_uncached: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(!rng_q) |=> struct_mem_type == VMECC_MT_UNCACHED)
		else $error("ranges disabled but type not uncacheable");
	a_cd_uncached: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cd_q || sib_q) |=> struct_mem_type == VMECC_MT_UNCACHED)
		else $error("cache disabled but type not uncacheable");
	a_basic_type: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cap_rd && !cap_wr && virt_present && cap_index == VMECC_IDX_BASIC)
		|=> cap_rdata[VMECC_MT_HI:VMECC_MT_LO] == MEM_TYPE)
		else $error("reported memory type changed");
endmodule // vmecc_checker
`default_nettype wire

/* hdl/vmecc_pkg.sv */
// package: register indices, field positions and class masks for the checker
package vmecc_pkg;
	// capability register indices
	localparam logic [11:0] VMECC_IDX_BASIC = 12'h480;
	localparam logic [11:0] VMECC_IDX_PIN = 12'h481;
	localparam logic [11:0] VMECC_IDX_PRI = 12'h482;
	localparam logic [11:0] VMECC_IDX_SEC = 12'h48B;
	localparam logic [11:0] VMECC_IDX_TPIN = 12'h48D;
	localparam logic [11:0] VMECC_IDX_TPRI = 12'h48E;
	// basic capability fields
	localparam int VMECC_TRUE_BIT = 55;
	localparam int VMECC_MT_LO = 50;
	localparam int VMECC_MT_HI = 53;
	localparam int VMECC_RANGE_EN_BIT = 11;
	// memory type encodings
	localparam logic [3:0] VMECC_MT_UNCACHED = 4'h0;
	localparam logic [3:0] VMECC_MT_WB = 4'h6;
	// reserved_one_class members of each control word
	localparam logic [31:0] VMECC_PIN_ONE_MASK = 32'h0000_0016;
	localparam logic [31:0] VMECC_PRI_ONE_MASK = 32'h0401_E172;
	localparam logic [63:0] VMECC_ZERO64 = 64'h0;
	// field widths and latency
	localparam int VMECC_WORD_W = 32;
	localparam int VMECC_REG_W = 64;
	localparam int VMECC_CHECK_LAT = 2;
endpackage : vmecc_pkg

/* tb/test_vmecc_checker.sv */
// self-checking testbench for the vm entry control checker
`timescale 1ns/10ps
`default_nettype none
module test_vmecc_checker;
	import vmecc_pkg::*;
	// ----------------------------------------
	// capability contents and derived limits
	// ----------------------------------------
	localparam logic [63:0] PIN_RAW = 64'h0000_003F_0000_0001;
	localparam logic [63:0] PRI_RAW = 64'h7FFF_FFFF_0000_0000;
	localparam logic [63:0] SEC_RAW = 64'h0000_00FF_0000_0000;
	localparam logic [31:0] PIN_LO = PIN_RAW[31:0] | VMECC_PIN_ONE_MASK;
	localparam logic [31:0] PRI_LO = PRI_RAW[31:0] | VMECC_PRI_ONE_MASK;
	localparam logic [31:0] PIN_HI = PIN_RAW[63:32];
	localparam logic [31:0] PRI_HI = PRI_RAW[63:32];
	// basic word: reserved top bits, true bit (clear here), memory type
	localparam logic [63:0] BASIC_M = 64'hFFBC_0000_0000_0000;
	localparam logic [63:0] BASIC_D = 64'h0018_0000_0000_0000;
	typedef struct packed {logic f; logic [63:0] d;
		logic [63:0] m;} vmecc_rexp_t;
	logic sys_clk = 1'b0, sys_rst = 1'b1, cap_rd = 1'b0, cap_wr = 1'b0;
	logic [11:0] cap_index = 12'h000;
	logic virt_present = 1'b1, entry_req = 1'b0, range_enable = 1'b1;
	logic cd_set = 1'b0, sib_cd = 1'b0;
	logic [31:0] pin_w = 32'h0, pri_w = 32'h0, seed = 32'h60A33565;
	logic [63:0] cap_rdata;
	logic cap_rvalid, cap_fault, entry_done, entry_fail, pin_fail, pri_fail;
	logic [3:0] struct_mem_type;
	vmecc_rexp_t rq[$];
	logic [2:0] eq[$];
	int error_cnt = 0, tests_run = 0, cyc = 0;
	// true capability off so the reserved-one class is enforced
	vmecc_checker #(.TRUE_CAP(1'b0), .MEM_TYPE(VMECC_MT_WB),
		.PIN_CAP_RAW(PIN_RAW), .PRI_CAP_RAW(PRI_RAW), .SEC_CAP(SEC_RAW))
	vmecc_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cap_rd(cap_rd), .cap_wr(cap_wr), .cap_index(cap_index),
		.virt_present(virt_present), .cap_rdata(cap_rdata),
		.cap_rvalid(cap_rvalid), .cap_fault(cap_fault),
		.entry_req(entry_req), .pin_controls(pin_w),
		.primary_controls(pri_w), .entry_done(entry_done),
		.entry_fail(entry_fail), .pin_fail(pin_fail),
		.primary_fail(pri_fail), .range_enable(range_enable),
		.cache_disable_setting(cd_set), .sibling_cache_disable(sib_cd),
		.struct_mem_type(struct_mem_type));
	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// request held up between back-to-back accesses; idle drops it
	task automatic acc(input logic wr, input logic [11:0] idx,
		input logic f, input logic [63:0] d, input logic [63:0] m);
		rq.push_back('{f, d & m, m});
		cap_wr = wr;
		cap_rd = ~wr;
		cap_index = idx;
		@(posedge sys_clk) #1;
	endtask
	task automatic idle();
		cap_rd = 1'b0;
		cap_wr = 1'b0;
		@(posedge sys_clk) #1;
	endtask
	// expectation worked out from both halves of each capability word
	task automatic ent(input logic [31:0] p, input logic [31:0] q);
		logic pf, qf;
		pf = |((~p & PIN_LO) | (p & ~PIN_HI));
		qf = |((~q & PRI_LO) | (q & ~PRI_HI));
		eq.push_back({pf | qf, pf, qf});
		entry_req = 1'b1;
		pin_w = p;
		pri_w = q;
		@(posedge sys_clk) #1;
		entry_req = 1'b0;
		@(posedge sys_clk) #1;
	endtask
	task automatic mt(input logic r, input logic c, input logic s,
		input logic [3:0] e);
		range_enable = r;
		cd_set = c;
		sib_cd = s;
		repeat (6) @(posedge sys_clk);
		#1 chk({60'h0, struct_mem_type}, {60'h0, e});
	endtask
	// ----------------------------------------
	// result watcher: oldest note against each answer
	// ----------------------------------------
	always @(negedge sys_clk) begin
		vmecc_rexp_t re;
		if (!sys_rst && (cap_rvalid || cap_fault)) begin
			if (rq.size() == 0) chk(64'h1, 64'h0);
			else begin
				re = rq.pop_front();
				chk({cap_fault, cap_rvalid}, {re.f, ~re.f});
				chk(cap_rdata & re.m, re.d);
			end
		end
		if (!sys_rst && entry_done) begin
			if (eq.size() == 0) chk(64'h1, 64'h0);
			else chk({entry_fail, pin_fail, pri_fail}, eq.pop_front());
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] x, y;
		repeat (4) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		mt(1'b1, 1'b0, 1'b0, VMECC_MT_WB);
		acc(1'b0, VMECC_IDX_BASIC, 1'b0, BASIC_D, BASIC_M);
		acc(1'b0, VMECC_IDX_PIN, 1'b0, {PIN_HI, PIN_LO}, '1);
		acc(1'b0, VMECC_IDX_PRI, 1'b0, {PRI_HI, PRI_LO}, '1);
		acc(1'b0, VMECC_IDX_SEC, 1'b0, SEC_RAW, '1);
		acc(1'b0, VMECC_IDX_TPIN, 1'b1, 64'h0, '1);
		acc(1'b0, VMECC_IDX_TPRI, 1'b1, 64'h0, '1);
		acc(1'b0, 12'h483, 1'b1, 64'h0, '1);
		acc(1'b1, VMECC_IDX_PIN, 1'b1, 64'h0, '1);
		acc(1'b0, VMECC_IDX_PIN, 1'b0, {PIN_HI, PIN_LO}, '1);
		virt_present = 1'b0;
		acc(1'b0, VMECC_IDX_BASIC, 1'b1, 64'h0, '1);
		idle();
		virt_present = 1'b1;
		$display("test register reads done");
		ent(PIN_LO, PRI_LO);
		for (int i = 0; i < 32; i++) begin
			if (PIN_LO[i]) ent(PIN_LO & ~(32'h1 << i), PRI_LO);
			if (PRI_LO[i]) ent(PIN_LO, PRI_LO & ~(32'h1 << i));
		end
		ent(PIN_LO | 32'h0000_0020, PRI_LO);
		ent(PIN_LO | 32'h0000_0040, PRI_LO);
		ent(PIN_LO, PRI_LO | 32'h8000_0000);
		ent(32'h0, 32'hFFFF_FFFF);
		$display("test directed entries done");
		for (int n = 0; n < 60; n++) begin
			x = xs();
			y = xs();
			x = (x & PIN_HI) | PIN_LO;
			y = (y & PRI_HI) | PRI_LO;
			if (seed[31]) x ^= 32'h1 << seed[4:0];
			if (seed[30]) y ^= 32'h1 << seed[9:5];
			ent(x, y);
		end
		$display("test random entries done");
		mt(1'b0, 1'b0, 1'b0, VMECC_MT_UNCACHED);
		acc(1'b0, VMECC_IDX_BASIC, 1'b0, BASIC_D, BASIC_M);
		idle();
		mt(1'b1, 1'b1, 1'b0, VMECC_MT_UNCACHED);
		acc(1'b0, VMECC_IDX_BASIC, 1'b0, BASIC_D, BASIC_M);
		idle();
		mt(1'b1, 1'b0, 1'b1, VMECC_MT_UNCACHED);
		mt(1'b1, 1'b0, 1'b0, VMECC_MT_WB);
		$display("test memory type done");
		repeat (4) @(posedge sys_clk);
		chk(64'(rq.size() + eq.size()), 64'h0);
		close_out();
	end
endmodule // test_vmecc_checker
`default_nettype wire
